/* design/idi_defines.svh */
`ifndef IDI_DEFINES_SVH
`define IDI_DEFINES_SVH

// register references seen by the panel start here
`define IDI_REF_BASE     17'h09C41
`define IDI_IMAGE_DEPTH  14'h270F
`define IDI_DATA_W       16

// block sizes, in image order
`define IDI_OUT_LEN      14'h1000
`define IDI_F2H_LEN      14'h0200
`define IDI_RES3_LEN     14'h0200
`define IDI_RW9_LEN      14'h0009
`define IDI_REQ_LEN      14'h0005
`define IDI_RW114_LEN    14'h0072
`define IDI_RW54_LEN     14'h0036
`define IDI_RSP_LEN      14'h0004
`define IDI_RO50_LEN     14'h0032
`define IDI_STAT_LEN     14'h0023
`define IDI_IN_LEN       14'h1000
`define IDI_H2F_LEN      14'h0200

// block starts, as image indices (reference minus base)
`define IDI_OUT_FIRST    14'h0000
`define IDI_F2H_FIRST    (`IDI_OUT_FIRST + `IDI_OUT_LEN)
`define IDI_RES3_FIRST   (`IDI_F2H_FIRST + `IDI_F2H_LEN)
`define IDI_RW9_FIRST    (`IDI_RES3_FIRST + `IDI_RES3_LEN)
`define IDI_REQ_FIRST    (`IDI_RW9_FIRST + `IDI_RW9_LEN)
`define IDI_RW114_FIRST  (`IDI_REQ_FIRST + `IDI_REQ_LEN)
`define IDI_RW54_FIRST   (`IDI_RW114_FIRST + `IDI_RW114_LEN)
`define IDI_RSP_FIRST    (`IDI_RW54_FIRST + `IDI_RW54_LEN)
`define IDI_RO50_FIRST   (`IDI_RSP_FIRST + `IDI_RSP_LEN)
`define IDI_STAT_FIRST   (`IDI_RO50_FIRST + `IDI_RO50_LEN)
`define IDI_IN_FIRST     (`IDI_STAT_FIRST + `IDI_STAT_LEN)
`define IDI_H2F_FIRST    (`IDI_IN_FIRST + `IDI_IN_LEN)

// gateway status word and its test mode bit
`define IDI_STATUS_REF   17'h0B14F
`define IDI_TEST_BIT     5

// image words per module kind
`define IDI_DIN_IN_CNT   14'h0002
`define IDI_DOUT_IN_CNT  14'h0001
`define IDI_DOUT_OUT_CNT 14'h0001
`define IDI_AIN_IN_CNT   14'h0004
`define IDI_AOUT_IN_CNT  14'h0002
`define IDI_AOUT_OUT_CNT 14'h0002

`endif

/* design/idi_pkg.sv */
package idi_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACCESS,
		ST_MIRROR,
		ST_FINISH,
		ST_ACKED
	} idi_state_t;

	typedef enum logic [1:0] {
		OWN_IO,
		OWN_FB,
		OWN_HMI
	} idi_owner_t;

	typedef enum logic [1:0] {
		IO_RESTART,
		IO_NEW_MODULE,
		IO_WR_IN,
		IO_RD_OUT
	} idi_io_op_t;

	typedef enum logic [1:0] {
		KIND_DIN,
		KIND_DOUT,
		KIND_AIN,
		KIND_AOUT
	} idi_kind_t;

endpackage : idi_pkg

/* design/idi_image_mem.sv */
`timescale 1ns/1ps
`include "idi_defines.svh"

module idi_image_mem (
	// clock
	input  wire logic                   core_clk,
	// single access port
	input  wire logic                   we,
	input  wire logic [13:0]            addr,
	input  wire logic [`IDI_DATA_W-1:0] wdata,
	output logic      [`IDI_DATA_W-1:0] rdata_r
);

	logic [`IDI_DATA_W-1:0] store [0:`IDI_IMAGE_DEPTH-1];

	// no reset on the array so it maps onto block memory
	always_ff @(posedge core_clk) begin
		if (we) begin
			store[addr] <= wdata;
		end
		rdata_r <= store[addr];
	end

endmodule : idi_image_mem

/* design/idi_image_map.sv */
`timescale 1ns/1ps
`include "idi_defines.svh"


module idi_image_map
	import idi_pkg::*;
(
	// clock and reset
	input  wire logic                   core_clk,
	input  wire logic                   reset,
	// test mode level from the pin
	input  wire logic                   test_mode_pin,
	output logic                        test_mode_active,
	// panel port, image index = reference - 40001
	input  wire logic                   hmi_req,
	input  wire logic                   hmi_we,
	input  wire logic [13:0]            hmi_addr,
	input  wire logic [`IDI_DATA_W-1:0] hmi_wdata,
	input  wire logic [9:0]             hmi_in_len,
	output logic                        hmi_ack,
	output logic                        hmi_refused,
	output logic      [`IDI_DATA_W-1:0] hmi_rdata,
	// fieldbus master port
	input  wire logic                   fb_req,
	input  wire logic                   fb_we,
	input  wire logic [13:0]            fb_addr,
	input  wire logic [`IDI_DATA_W-1:0] fb_wdata,
	output logic                        fb_ack,
	output logic                        fb_refused,
	output logic      [`IDI_DATA_W-1:0] fb_rdata,
	// island bus side
	input  wire logic                   io_req,
	input  wire idi_io_op_t             io_op,
	input  wire idi_kind_t              io_kind,
	input  wire logic [1:0]             io_idx,
	input  wire logic [`IDI_DATA_W-1:0] io_wdata,
	output logic                        io_ack,
	output logic                        io_refused,
	output logic      [`IDI_DATA_W-1:0] io_rdata,
	output logic      [12:0]            io_in_base,
	output logic      [12:0]            io_out_base
);

	localparam logic [13:0] STAT_IDX =
		14'(`IDI_STATUS_REF - `IDI_REF_BASE);

	////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic in_blk(input logic [13:0] a,
		input logic [13:0] first, input logic [13:0] len);
		in_blk = (a >= first) && (a < first + len);
	endfunction : in_blk

	function automatic logic [13:0] in_cnt(input idi_kind_t k);
		case (k)
			KIND_DIN:  in_cnt = `IDI_DIN_IN_CNT;
			KIND_DOUT: in_cnt = `IDI_DOUT_IN_CNT;
			KIND_AIN:  in_cnt = `IDI_AIN_IN_CNT;
			KIND_AOUT: in_cnt = `IDI_AOUT_IN_CNT;
			default:   in_cnt = 14'h0000;
		endcase
	endfunction : in_cnt

	function automatic logic [13:0] out_cnt(input idi_kind_t k);
		case (k)
			KIND_DOUT: out_cnt = `IDI_DOUT_OUT_CNT;
			KIND_AOUT: out_cnt = `IDI_AOUT_OUT_CNT;
			default:   out_cnt = 14'h0000;
		endcase
	endfunction : out_cnt

	////////////////////////////////////////////////////////////////////////
	// test mode synchroniser

	logic tm_meta_r;
	logic tm_r;

	always_ff @(posedge core_clk) begin
		if (reset) begin
			tm_meta_r <= 1'b0;
			tm_r      <= 1'b0;
		end else begin
			tm_meta_r <= test_mode_pin;
			tm_r      <= tm_meta_r;
		end
	end

	assign test_mode_active = tm_r;

	////////////////////////////////////////////////////////////////////////
	// request decode

	idi_state_t             state_r;
	idi_state_t             state_nxt;
	idi_owner_t             own_r;
	idi_io_op_t             op_r;
	idi_kind_t              kind_r;
	idi_kind_t              cur_kind_r;
	logic                   mod_valid_r;
	logic [12:0]            next_in_r;
	logic [12:0]            next_out_r;
	logic [13:0]            addr_r;
	logic [`IDI_DATA_W-1:0] wdata_r;
	logic                   we_r;
	logic                   ok_r;
	logic                   mem_r;
	logic                   ack_r;
	logic                   refused_r;
	logic [`IDI_DATA_W-1:0] rdata_r;
	logic [`IDI_DATA_W-1:0] mem_rdata;

	// fixed priority: island bus, then fieldbus, then panel
	wire io_sel  = io_req;
	wire fb_sel  = fb_req & ~io_req;
	wire hmi_sel = hmi_req & ~io_req & ~fb_req;
	wire any_sel = io_req | fb_req | hmi_req;

	// fixed block placement, index = reference - base
	wire fb_out  = in_blk(fb_addr, `IDI_OUT_FIRST, `IDI_OUT_LEN);
	wire fb_ok   = fb_we ? (fb_out & ~tm_r)
		: (fb_addr < `IDI_IMAGE_DEPTH);
	wire hmi_h2f = in_blk(hmi_addr, `IDI_H2F_FIRST,
		{4'h0, hmi_in_len});
	wire hmi_out = tm_r & in_blk(hmi_addr, `IDI_OUT_FIRST,
		`IDI_OUT_LEN);
	wire hmi_rtp = in_blk(hmi_addr, `IDI_REQ_FIRST, `IDI_REQ_LEN);
	wire hmi_ok  = hmi_we ? (hmi_h2f | hmi_out | hmi_rtp)
		: (hmi_addr < `IDI_IMAGE_DEPTH);

	// island bus slots follow module order along the bus
	wire [13:0] new_out = {1'b0, next_out_r} + out_cnt(io_kind);
	wire [13:0] new_in  = {1'b0, next_in_r} + in_cnt(io_kind);
	wire [13:0] idx14   = {12'h000, io_idx};
	wire [13:0] io_addr = (io_op == IO_WR_IN)
		? 14'(`IDI_IN_FIRST + {1'b0, io_in_base} + idx14)
		: 14'(`IDI_OUT_FIRST + {1'b0, io_out_base} + idx14);
	wire io_ok =
		(io_op == IO_RESTART) ? 1'b1 :
		(io_op == IO_NEW_MODULE) ? (new_out <= `IDI_OUT_LEN &&
			new_in <= `IDI_IN_LEN) :
		(io_op == IO_WR_IN) ? (mod_valid_r && idx14 < in_cnt(cur_kind_r)) :
		(mod_valid_r && idx14 < out_cnt(cur_kind_r));
	wire io_mem = (io_op == IO_WR_IN) || (io_op == IO_RD_OUT);

	wire [13:0] req_addr = io_sel ? io_addr : (fb_sel ? fb_addr : hmi_addr);
	wire        req_we   = io_sel ? (io_op == IO_WR_IN)
		: (fb_sel ? fb_we : hmi_we);
	wire        req_ok   = io_sel ? io_ok : (fb_sel ? fb_ok : hmi_ok);
	wire        req_mem  = io_sel ? io_mem : 1'b1;
	wire [`IDI_DATA_W-1:0] req_wdata = io_sel ? io_wdata
		: (fb_sel ? fb_wdata : hmi_wdata);
	wire idi_owner_t req_own = io_sel ? OWN_IO : (fb_sel ? OWN_FB : OWN_HMI);

	////////////////////////////////////////////////////////////////////////
	// memory port; the panel table only shadows fieldbus writes to the lowest 512 outputs

	wire mem_we = (state_r == ST_ACCESS && mem_r && ok_r && we_r)
		| (state_r == ST_MIRROR);
	wire [13:0] mem_addr = (state_r == ST_MIRROR)
		? 14'(addr_r + `IDI_F2H_FIRST) : addr_r;

	idi_image_mem u_mem (
		.core_clk (core_clk),
		.we       (mem_we),
		.addr     (mem_addr),
		.wdata    (wdata_r),
		.rdata_r  (mem_rdata)
	);

	// status word carries live test mode
	wire [`IDI_DATA_W-1:0] read_val = (addr_r != STAT_IDX) ? mem_rdata
		: (mem_rdata & ~(`IDI_DATA_W'(1) << `IDI_TEST_BIT))
		| (`IDI_DATA_W'(tm_r) << `IDI_TEST_BIT);

	////////////////////////////////////////////////////////////////////////
	// sequencer

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:   if (any_sel) state_nxt = ST_ACCESS;
			ST_ACCESS: state_nxt = (own_r == OWN_FB && we_r && ok_r
				&& addr_r < `IDI_F2H_LEN) ? ST_MIRROR : ST_FINISH;
			ST_MIRROR: state_nxt = ST_FINISH;
			ST_FINISH: state_nxt = ST_ACKED;
			ST_ACKED:  state_nxt = ST_IDLE;
			default:   state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			state_r <= ST_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			own_r   <= OWN_IO;
			op_r    <= IO_RESTART;
			kind_r  <= KIND_DIN;
			addr_r  <= 14'h0000;
			wdata_r <= 16'h0000;
			we_r    <= 1'b0;
			ok_r    <= 1'b0;
			mem_r   <= 1'b0;
		end else if (state_r == ST_IDLE && any_sel) begin
			own_r   <= req_own;
			op_r    <= io_op;
			kind_r  <= io_kind;
			addr_r  <= req_addr;
			wdata_r <= req_wdata;
			we_r    <= req_we;
			ok_r    <= req_ok;
			mem_r   <= req_mem;
		end
	end

	// answer stands for one cycle, data with it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_r     <= 1'b0;
			refused_r <= 1'b0;
			rdata_r   <= 16'h0000;
		end else begin
			ack_r     <= (state_r == ST_FINISH);
			refused_r <= (state_r == ST_FINISH) && !ok_r;
			if (state_r == ST_FINISH && mem_r && ok_r && !we_r) begin
				rdata_r <= read_val;
			end
		end
	end

	// slot allocation walks the bus from the gateway outward
	always_ff @(posedge core_clk) begin
		if (reset) begin
			next_in_r   <= 13'h0000;
			next_out_r  <= 13'h0000;
			io_in_base  <= 13'h0000;
			io_out_base <= 13'h0000;
			cur_kind_r  <= KIND_DIN;
			mod_valid_r <= 1'b0;
		end else if (state_r == ST_FINISH && own_r == OWN_IO && ok_r) begin
			if (op_r == IO_RESTART) begin
				next_in_r   <= 13'h0000;
				next_out_r  <= 13'h0000;
				mod_valid_r <= 1'b0;
			end else if (op_r == IO_NEW_MODULE) begin
				io_in_base  <= next_in_r;
				io_out_base <= next_out_r;
				next_in_r   <= 13'(next_in_r + in_cnt(kind_r));
				next_out_r  <= 13'(next_out_r + out_cnt(kind_r));
				cur_kind_r  <= kind_r;
				mod_valid_r <= 1'b1;
			end
		end
	end

	assign hmi_ack     = ack_r & (own_r == OWN_HMI);
	assign fb_ack      = ack_r & (own_r == OWN_FB);
	assign io_ack      = ack_r & (own_r == OWN_IO);
	assign hmi_refused = refused_r & (own_r == OWN_HMI);
	assign fb_refused  = refused_r & (own_r == OWN_FB);
	assign io_refused  = refused_r & (own_r == OWN_IO);
	assign hmi_rdata   = rdata_r;
	assign fb_rdata    = rdata_r;
	assign io_rdata    = rdata_r;

	////////////////////////////////////////////////////////////////////////
	// checks

	ack_one_cycle_a: assert property (@(posedge core_clk) disable iff (reset)
		ack_r |=> !ack_r) else $error("answer longer than one cycle");

	fb_test_block_a: assert property (@(posedge core_clk)
		disable iff (reset)
		state_r == ST_IDLE && fb_sel && fb_we && tm_r
		|-> ##3 fb_ack && fb_refused)
		else $error("fieldbus output write taken in test mode");

	mirror_copy_a: assert property (@(posedge core_clk)
		disable iff (reset)
		mem_we && state_r == ST_ACCESS && own_r == OWN_FB
		&& addr_r < `IDI_F2H_LEN
		|=> mem_we && mem_addr == 14'($past(mem_addr) + `IDI_F2H_FIRST))
		else $error("output write not mirrored to panel table");

	status_bit_a: assert property (@(posedge core_clk)
		disable iff (reset)
		state_r == ST_FINISH && addr_r == STAT_IDX && ok_r && !we_r
		|=> rdata_r[`IDI_TEST_BIT] == $past(tm_r))
		else $error("status word test bit wrong");

	hmi_read_all_a: assert property (@(posedge core_clk)
		disable iff (reset)
		state_r == ST_IDLE && hmi_sel && !hmi_we
		&& hmi_addr < `IDI_IMAGE_DEPTH
		|-> ##3 ack_r && !refused_r ##1 !ack_r)
		else $error("panel read refused or late");

	write_scope_a: assert property (@(posedge core_clk)
		disable iff (reset)
		mem_we |-> in_blk(mem_addr, `IDI_OUT_FIRST, `IDI_OUT_LEN)
		|| in_blk(mem_addr, `IDI_F2H_FIRST, `IDI_F2H_LEN)
		|| in_blk(mem_addr, `IDI_REQ_FIRST, `IDI_REQ_LEN)
		|| in_blk(mem_addr, `IDI_IN_FIRST, `IDI_IN_LEN)
		|| in_blk(mem_addr, `IDI_H2F_FIRST, `IDI_H2F_LEN))
		else $error("write outside writable blocks");

	slot_order_a: assert property (@(posedge core_clk)
		disable iff (reset)
		state_r == ST_FINISH && own_r == OWN_IO && ok_r
		&& op_r == IO_NEW_MODULE
		|=> io_out_base == $past(next_out_r)
		&& io_in_base == $past(next_in_r))
		else $error("module slot not at next free place");

	slot_bound_a: assert property (@(posedge core_clk)
		disable iff (reset)
		state_r == ST_IDLE && io_sel && io_op == IO_WR_IN
		&& idx14 >= in_cnt(cur_kind_r)
		|-> ##3 io_ack && io_refused)
		else $error("input word beyond module share accepted");

	hmi_out_gate_a: assert property (@(posedge core_clk)
		disable iff (reset)
		state_r == ST_ACCESS && own_r == OWN_HMI && we_r
		&& addr_r < `IDI_OUT_LEN && !$past(tm_r)
		|-> !mem_we)
		else $error("panel wrote outputs outside test mode");

endmodule : idi_image_map

/* sim/idi_panel_model.sv */
`timescale 1ns/1ps
`include "idi_defines.svh"

module idi_panel_model (
	// clock
	input  wire logic                   core_clk,
	// request side of the panel port
	output logic                        hmi_req,
	output logic                        hmi_we,
	output logic      [13:0]            hmi_addr,
	output logic      [`IDI_DATA_W-1:0] hmi_wdata,
	// answer side
	input  wire logic                   hmi_ack,
	input  wire logic                   hmi_refused,
	input  wire logic [`IDI_DATA_W-1:0] hmi_rdata
);
	// idle cycles before each command; raised to act as a slow panel
	int gap;

	initial begin
		gap       = 0;
		hmi_req   = 1'b0;
		hmi_we    = 1'b0;
		hmi_addr  = 14'h0000;
		hmi_wdata = 16'h0000;
	end

	////////////////////////////////////////////////////////////////////////
	// one register command, held whole until the answer is sampled
	task automatic access(
		input  logic        we,
		input  logic [13:0] a,
		input  logic [15:0] d,
		output logic        refd,
		output logic [15:0] rd,
		output logic        lost
	);
		int n;
		repeat (gap) @(negedge core_clk);
		// output writes only come in test mode or to provoke a refusal
		hmi_we    <= we;
		hmi_addr  <= a;
		hmi_wdata <= d;
		hmi_req   <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (hmi_ack !== 1'b1 && n < 40);
		refd = hmi_refused;
		rd   = hmi_rdata;
		lost = (n >= 40);
		// released lines show the inverse so a stale value is never trusted
		hmi_req   <= 1'b0;
		hmi_we    <= ~we;
		hmi_addr  <= ~a;
		hmi_wdata <= ~d;
		// spare cycle keeps the next take clear of the ack
		@(negedge core_clk);
	endtask : access

endmodule : idi_panel_model

/* sim/tb.sv */
`timescale 1ns/1ps
`include "idi_defines.svh"

module tb import idi_pkg::*;;
	// clock, reset and test pin
	logic        core_clk, reset, test_mode_pin, test_mode_active;
	// panel port
	logic        hmi_req, hmi_we, hmi_ack, hmi_refused;
	logic [13:0] hmi_addr;
	logic [15:0] hmi_wdata, hmi_rdata;
	logic [9:0]  hmi_in_len;
	// fieldbus port
	logic        fb_req, fb_we, fb_ack, fb_refused;
	logic [13:0] fb_addr;
	logic [15:0] fb_wdata, fb_rdata;
	// island bus port
	logic        io_req, io_ack, io_refused;
	idi_io_op_t  io_op;
	idi_kind_t   io_kind;
	logic [1:0]  io_idx;
	logic [15:0] io_wdata, io_rdata;
	logic [12:0] io_in_base, io_out_base;
	int          mismatches, comparisons;

	localparam logic        WR = 1'b1, RD = 1'b0, OK = 1'b0, RF = 1'b1;
	localparam logic [15:0] NIL = 16'h0000;

	idi_image_map dut_u (
		.core_clk, .reset, .test_mode_pin, .test_mode_active,
		.hmi_req, .hmi_we, .hmi_addr, .hmi_wdata, .hmi_in_len, .hmi_ack,
		.hmi_refused, .hmi_rdata, .fb_req, .fb_we, .fb_addr, .fb_wdata,
		.fb_ack, .fb_refused, .fb_rdata, .io_req, .io_op, .io_kind,
		.io_idx, .io_wdata, .io_ack, .io_refused, .io_rdata, .io_in_base,
		.io_out_base
	);

	idi_panel_model pnl_u (
		.core_clk, .hmi_req, .hmi_we, .hmi_addr, .hmi_wdata, .hmi_ack,
		.hmi_refused, .hmi_rdata
	);

	////////////////////////////////////////////////////////////////////////
	function automatic logic [13:0] ix(input int refno);
		return 14'(refno - 40001);
	endfunction : ix

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic close_out;
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out

	// refusal always judged; read data only on an accepted read
	task automatic judge(input logic r, input logic [15:0] q,
		input logic er, input logic [15:0] ed, input logic rd_op);
		chk({15'h0000, r}, {15'h0000, er});
		if (rd_op && !er)
			chk(q, ed);
	endtask : judge

	task automatic hmi(input logic we, input logic [13:0] a,
		input logic [15:0] d, input logic er, input logic [15:0] ed);
		logic        r, lost;
		logic [15:0] q;
		pnl_u.access(we, a, d, r, q, lost);
		chk({15'h0000, lost}, NIL);
		judge(r, q, er, ed, !we);
	endtask : hmi

	task automatic fb(input logic we, input logic [13:0] a,
		input logic [15:0] d, input logic er, input logic [15:0] ed);
		int n;
		fb_we    <= we;
		fb_addr  <= a;
		fb_wdata <= d;
		fb_req   <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (fb_ack !== 1'b1 && n < 40);
		chk({15'h0000, n >= 40}, NIL);
		judge(fb_refused, fb_rdata, er, ed, !we);
		fb_req   <= 1'b0;
		fb_addr  <= ~a;
		fb_wdata <= ~d;
		@(negedge core_clk);
	endtask : fb

	task automatic io(input idi_io_op_t op, input idi_kind_t k,
		input logic [1:0] i, input logic [15:0] d, input logic er,
		input logic [15:0] ed);
		int n;
		io_op    <= op;
		io_kind  <= k;
		io_idx   <= i;
		io_wdata <= d;
		io_req   <= 1'b1;
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (io_ack !== 1'b1 && n < 40);
		chk({15'h0000, n >= 40}, NIL);
		judge(io_refused, io_rdata, er, ed, op == IO_RD_OUT);
		io_req   <= 1'b0;
		io_wdata <= ~d;
		@(negedge core_clk);
	endtask : io

	////////////////////////////////////////////////////////////////////////
	task automatic t_h2f;
		hmi(WR, ix(49488), 16'h1234, OK, NIL);
		hmi(WR, ix(49491), 16'hBEEF, OK, NIL);
		hmi(WR, ix(49492), 16'hDEAD, RF, NIL);
		hmi(RD, ix(49488), NIL, OK, 16'h1234);
		hmi(RD, ix(49491), NIL, OK, 16'hBEEF);
	endtask : t_h2f

	task automatic t_outputs;
		fb(WR, ix(40001), 16'h0001, OK, NIL);
		fb(WR, ix(44096), 16'hA5A5, OK, NIL);
		fb(WR, ix(44097), 16'h5A5A, RF, NIL);
		fb(WR, ix(40003), 16'hFFE0, OK, NIL);
		fb(RD, ix(44096), NIL, OK, 16'hA5A5);
		pnl_u.gap = 3;
		hmi(RD, ix(40001), NIL, OK, 16'h0001);
		hmi(RD, ix(44097), NIL, OK, 16'h0001);
		hmi(WR, ix(40001), 16'hFFFF, RF, NIL);
		hmi(RD, ix(40001), NIL, OK, 16'h0001);
		pnl_u.gap = 0;
	endtask : t_outputs

	task automatic t_island;
		io(IO_RESTART, KIND_DIN, 2'h0, NIL, OK, NIL);
		io(IO_NEW_MODULE, KIND_DOUT, 2'h0, NIL, OK, NIL);
		chk({3'h0, io_out_base}, NIL);
		io(IO_RD_OUT, KIND_DOUT, 2'h0, NIL, OK, 16'h0001);
		io(IO_RD_OUT, KIND_DOUT, 2'h1, NIL, RF, NIL);
		io(IO_NEW_MODULE, KIND_DIN, 2'h0, NIL, OK, NIL);
		chk({3'h0, io_in_base}, 16'h0001);
		io(IO_WR_IN, KIND_DIN, 2'h0, 16'h00C3, OK, NIL);
		io(IO_WR_IN, KIND_DIN, 2'h1, NIL, OK, NIL);
		io(IO_WR_IN, KIND_DIN, 2'h2, 16'h0001, RF, NIL);
		hmi(RD, ix(45393), NIL, OK, 16'h00C3);
		io(IO_NEW_MODULE, KIND_AIN, 2'h0, NIL, OK, NIL);
		chk({3'h0, io_in_base}, 16'h0003);
		io(IO_WR_IN, KIND_AIN, 2'h3, 16'h7FF0, OK, NIL);
		hmi(RD, ix(45398), NIL, OK, 16'h7FF0);
		io(IO_NEW_MODULE, KIND_AOUT, 2'h0, NIL, OK, NIL);
		chk({3'h0, io_in_base}, 16'h0007);
		chk({3'h0, io_out_base}, 16'h0001);
		io(IO_WR_IN, KIND_AOUT, 2'h2, 16'h0001, RF, NIL);
		io(IO_RD_OUT, KIND_AOUT, 2'h1, NIL, OK, 16'hFFE0);
	endtask : t_island

	task automatic t_test_mode;
		logic        r, lost;
		logic [15:0] q;
		int          n;
		chk({15'h0000, test_mode_active}, NIL);
		test_mode_pin <= 1'b1;
		n = 0;
		while (test_mode_active !== 1'b1 && n < 8) begin
			@(negedge core_clk);
			n++;
		end
		chk({15'h0000, test_mode_active}, 16'h0001);
		pnl_u.access(RD, ix(45391), NIL, r, q, lost);
		chk({15'h0000, lost}, NIL);
		chk({15'h0000, r}, NIL);
		chk({15'h0000, q[5]}, 16'h0001);
		hmi(WR, ix(40002), 16'h0002, OK, NIL);
		hmi(RD, ix(40002), NIL, OK, 16'h0002);
		fb(WR, ix(40002), 16'h0003, RF, NIL);
		fb(RD, ix(45393), NIL, OK, 16'h00C3);
		fb(RD, ix(40002), NIL, OK, 16'h0002);
		test_mode_pin <= 1'b0;
		repeat (6) @(negedge core_clk);
		chk({15'h0000, test_mode_active}, NIL);
		pnl_u.access(RD, ix(45391), NIL, r, q, lost);
		chk({15'h0000, lost}, NIL);
		chk({15'h0000, q[5]}, NIL);
	endtask : t_test_mode

	task automatic t_bounds;
		hmi_in_len <= 10'h200;
		@(negedge core_clk);
		hmi(WR, ix(49999), 16'hC0DE, OK, NIL);
		hmi(RD, ix(49999), NIL, OK, 16'hC0DE);
		hmi(RD, 14'h270F, NIL, RF, NIL);
		hmi(WR, ix(45130), 16'h0042, OK, NIL);
		hmi(RD, ix(45130), NIL, OK, 16'h0042);
		fb(WR, ix(41034), 16'h0BAD, OK, NIL);
		hmi(RD, ix(45130), NIL, OK, 16'h0042);
		hmi(WR, ix(44609), 16'h0001, RF, NIL);
		hmi(WR, ix(45129), 16'h0001, RF, NIL);
		hmi(WR, ix(45135), 16'h0001, RF, NIL);
		hmi(WR, ix(45307), 16'h0001, RF, NIL);
		hmi(WR, ix(45357), 16'h0001, RF, NIL);
	endtask : t_bounds

	////////////////////////////////////////////////////////////////////////
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// about 50 commands of under 10 cycles each; generous margin
	initial begin
		repeat (20000) @(posedge core_clk);
		mismatches++;
		close_out;
	end

	initial begin
		mismatches    = 0;
		comparisons   = 0;
		reset         = 1'b1;
		test_mode_pin = 1'b0;
		hmi_in_len    = 10'h004;
		fb_req        = 1'b0;
		fb_we         = 1'b0;
		fb_addr       = 14'h0000;
		fb_wdata      = NIL;
		io_req        = 1'b0;
		io_op         = IO_RESTART;
		io_kind       = KIND_DIN;
		io_idx        = 2'h0;
		io_wdata      = NIL;
		repeat (20) @(negedge core_clk);
		reset <= 1'b0;
		@(negedge core_clk);
		t_h2f;
		t_outputs;
		t_island;
		t_test_mode;
		t_bounds;
		close_out;
	end

endmodule : tb
